/* File: hw/smdcr_debounce.sv */
// debounce counter for one detection input, timed by the 32 kHz tick
`timescale 1ns/10ps
module smdcr_debounce import smdcr_pkg::*; #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic active,
	input wire logic [W-1:0] count,
	input wire logic reload,
	output logic deb
);
	logic [W-1:0] cnt_r, cnt_nxt; // remaining ticks
	logic deb_r, deb_nxt; // debounced level

	// ***************************************************
	// next state
	// ***************************************************
	always_comb begin
		cnt_nxt = cnt_r;
		deb_nxt = deb_r;
		if (!active) begin
			cnt_nxt = count;
			deb_nxt = 1'b0;
		end else if (count == '0) begin
			deb_nxt = 1'b1;
		end else if (reload && !deb_r) begin
			cnt_nxt = count;
		end else if (tick && !deb_r) begin
			if (cnt_r == '0) begin
				deb_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - 1'b1;
			end
		end
	end

	// registers only
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= W'(SMDCR_SDN_CNT_RST);
			deb_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			deb_r <= deb_nxt;
		end
	end

	assign deb = deb_r;

	// ***************************************************
	// checks
	// ***************************************************
	property p_passThru;
		@(posedge ref_clk) disable iff (!rst_b)
		(active && count == '0) |=> deb_r;
	endproperty
	a_passThru: assert property (p_passThru) else $error("zero count did not pass");

	property p_falseLoads;
		@(posedge ref_clk) disable iff (!rst_b)
		!active |=> (!deb_r && cnt_r == $past(count));
	endproperty
	a_falseLoads: assert property (p_falseLoads) else $error("false input did not reload");

	property p_restart;
		@(posedge ref_clk) disable iff (!rst_b)
		(active && reload && !deb_r && count != '0) |=> cnt_r == $past(count);
	endproperty
	a_restart: assert property (p_restart) else $error("new count not restarted");

	property p_expire;
		@(posedge ref_clk) disable iff (!rst_b)
		(active && tick && !reload && cnt_r == '0 && count != '0) |=> deb_r [*2];
	endproperty
	a_expire: assert property (p_expire) else $error("expired count not seen");
endmodule // smdcr_debounce

/* File: hw/smdcr_pkg.sv */
// shared constants and types for the sim mux detection control registers
package smdcr_pkg;
	// ***************************************************
	// register indices on the serial control port
	// ***************************************************
	localparam logic [7:0] SMDCR_IDX_STATUS = 8'h04;
	localparam logic [7:0] SMDCR_IDX_SDN_CNT = 8'h0b;
	localparam logic [7:0] SMDCR_IDX_CLK = 8'h0d;
	localparam logic [7:0] SMDCR_IDX_CTRL = 8'h0e;
	localparam logic [7:0] SMDCR_IDX_GP = 8'h15;
	// ***************************************************
	// values after reset
	// ***************************************************
	localparam logic [7:0] SMDCR_SDN_CNT_RST = 8'h04;
	localparam logic [7:0] SMDCR_BSI_CNT_RST = 8'h04;
	localparam logic [7:0] SMDCR_CLK_RST = 8'h00;
	localparam logic [7:0] SMDCR_CTRL_RST = 8'h00;
	localparam logic [7:0] SMDCR_GP_RST = 8'h00;
	// only the two pull bits of the general purpose register are stored
	localparam logic [7:0] SMDCR_GP_WMASK = 8'h03;
	// ***************************************************
	// field positions
	// ***************************************************
	localparam int SMDCR_CTL_OE_EN = 0;
	localparam int SMDCR_CTL_OE_POL = 1;
	localparam int SMDCR_CTL_BAT_IRQ = 2;
	localparam int SMDCR_CTL_BSI_LVL = 3;
	localparam int SMDCR_CTL_BSI_NOPD = 4;
	localparam int SMDCR_CTL_SDN_IRQ = 5;
	localparam int SMDCR_CTL_SDN_LVL = 6;
	localparam int SMDCR_CTL_SDN_NOPD = 7;
	localparam int SMDCR_CLK_SEL = 7;
	localparam int SMDCR_GP_PU = 0;
	localparam int SMDCR_GP_PD = 1;
	localparam int SMDCR_STAT_SDN = 1;
	localparam int SMDCR_STAT_BAT = 3;
	// ***************************************************
	// slave addresses (7-bit) chosen by the strap
	// ***************************************************
	localparam logic [6:0] SMDCR_ADDR_LOW = 7'h3c;
	localparam logic [6:0] SMDCR_ADDR_HIGH = 7'h3d;
	// ***************************************************
	// timing
	// ***************************************************
	localparam int SMDCR_REF_HZ = 20000000;
	localparam int SMDCR_OSC_HZ = 32768;
	// internal oscillator period in reference cycles, rounded down
	localparam logic [9:0] SMDCR_OSC_DIV = 10'(SMDCR_REF_HZ / SMDCR_OSC_HZ);
	// strap sampled this many link edges after reset release
	localparam logic [1:0] SMDCR_STRAP_CYC = 2'h3;
	// serial slave states, one-hot
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_ACKA = 9'h004,
		S_INDEX = 9'h008,
		S_ACKI = 9'h010,
		S_WRITE = 9'h020,
		S_ACKW = 9'h040,
		S_READ = 9'h080,
		S_RDACK = 9'h100
	} smdcr_i2c_t;
endpackage

/* File: hw/smdcr_top.sv */
// configuration and detection control with serial register slave
`timescale 1ns/10ps
module smdcr_top import smdcr_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic linkClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_b,
	input wire logic irqIn,
	output logic irqOut,
	output logic irqOe_b,
	input wire logic extClkIn,
	input wire logic bsiIn,
	input wire logic sdnIn,
	input wire logic dirPinIn,
	output logic bsiLevelSel,
	output logic autoDirEn,
	output logic dirCardToBb,
	output logic sdnPullUpEn,
	output logic sdnPullDnEn,
	output logic sim1PowerDown,
	output logic sim2PowerDown
);
	// ***************************************************
	// link domain: pin and event toggle synchronisers
	// ***************************************************
	logic sclS1_r, sclS2_r, sclS3_r; // serial clock, third is edge history
	logic sdaS1_r, sdaS2_r, sdaS3_r; // serial data, third is edge history
	logic irqS1_r, irqS2_r; // strap level
	logic batS1_r, batS2_r, batS3_r; // battery event toggle from ref domain
	logic sdnS1_r, sdnS2_r, sdnS3_r; // shutdown event toggle from ref domain
	logic batTgl_r, sdnTgl_r; // event toggles, ref domain

	// first stages feed only second stages
	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			{sclS1_r, sclS2_r, sclS3_r} <= 3'h7;
			{sdaS1_r, sdaS2_r, sdaS3_r} <= 3'h7;
			{irqS1_r, irqS2_r} <= 2'h0;
			{batS1_r, batS2_r, batS3_r} <= 3'h0;
			{sdnS1_r, sdnS2_r, sdnS3_r} <= 3'h0;
		end else begin
			{sclS1_r, sclS2_r, sclS3_r} <= {sclIn, sclS1_r, sclS2_r};
			{sdaS1_r, sdaS2_r, sdaS3_r} <= {sdaIn, sdaS1_r, sdaS2_r};
			{irqS1_r, irqS2_r} <= {irqIn, irqS1_r};
			{batS1_r, batS2_r, batS3_r} <= {batTgl_r, batS1_r, batS2_r};
			{sdnS1_r, sdnS2_r, sdnS3_r} <= {sdnTgl_r, sdnS1_r, sdnS2_r};
		end
	end

	logic sclRise, sclFall, busStart, busStop, batEvt, sdnEvt;
	assign sclRise = sclS2_r & ~sclS3_r;
	assign sclFall = ~sclS2_r & sclS3_r;
	assign busStart = sclS2_r & sclS3_r & sdaS3_r & ~sdaS2_r;
	assign busStop = sclS2_r & sclS3_r & ~sdaS3_r & sdaS2_r;
	assign batEvt = batS2_r ^ batS3_r;
	assign sdnEvt = sdnS2_r ^ sdnS3_r;

	// ***************************************************
	// link domain: serial slave and register file
	// ***************************************************
	smdcr_i2c_t st_r, st_nxt; // slave state
	logic [7:0] shift_r, shift_nxt; // byte in or out
	logic [3:0] bits_r, bits_nxt; // bits moved in this byte
	logic sdaLow_r, sdaLow_nxt; // pull data line low
	logic rw_r, rw_nxt; // read request
	logic [7:0] idx_r, idx_nxt; // register index, steps after each acknowledged data byte
	logic [7:0] sdnCnt_r, sdnCnt_nxt; // shutdown debounce count
	logic [7:0] clkCtl_r, clkCtl_nxt; // clock source control
	logic [7:0] devCtl_r, devCtl_nxt; // device control
	logic [7:0] gp_r, gp_nxt; // pull control, reserved bits held zero
	logic statBat_r, statBat_nxt; // sticky battery removal
	logic statSdn_r, statSdn_nxt; // sticky shutdown event
	logic cntTgl_r, cntTgl_nxt; // count update toggle toward ref domain
	logic [1:0] strapCnt_r, strapCnt_nxt; // waits for the strap synchroniser
	logic strapHigh_r, strapHigh_nxt; // captured address strap
	logic irqDrv_r, irqDrv_nxt; // interrupt line pulled low
	logic wrEn, rdClr, loadRd; // write strobe, status read, read byte load
	logic [7:0] rdData; // read mux
	logic [6:0] devAddr; // own address

	// read mux; unmapped indices read zero
	function automatic logic [7:0] regRead(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			SMDCR_IDX_STATUS: begin
				v[SMDCR_STAT_BAT] = statBat_r;
				v[SMDCR_STAT_SDN] = statSdn_r;
			end
			SMDCR_IDX_SDN_CNT: v = sdnCnt_r;
			SMDCR_IDX_CLK: v = clkCtl_r;
			SMDCR_IDX_CTRL: v = devCtl_r;
			SMDCR_IDX_GP: v = gp_r & SMDCR_GP_WMASK;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	assign devAddr = strapHigh_r ? SMDCR_ADDR_HIGH : SMDCR_ADDR_LOW;
	assign rdData = regRead(idx_r);

	// byte engine: sample on rising clock, drive on falling clock
	always_comb begin
		st_nxt = st_r;
		shift_nxt = shift_r;
		bits_nxt = bits_r;
		sdaLow_nxt = sdaLow_r;
		rw_nxt = rw_r;
		idx_nxt = idx_r;
		wrEn = 1'b0;
		loadRd = 1'b0;
		if (busStop) begin
			st_nxt = S_IDLE;
			sdaLow_nxt = 1'b0;
		// no answer until the strap is known
		end else if (busStart && strapCnt_r == SMDCR_STRAP_CYC) begin
			st_nxt = S_ADDR;
			bits_nxt = 4'h0;
			sdaLow_nxt = 1'b0;
		end else if (sclRise) begin
			if (st_r == S_ADDR || st_r == S_INDEX || st_r == S_WRITE) begin
				shift_nxt = {shift_r[6:0], sdaS2_r};
				bits_nxt = bits_r + 4'h1;
			end
			// master not acknowledging ends the read
			if (st_r == S_RDACK && sdaS2_r) begin
				st_nxt = S_IDLE;
			end
		end else if (sclFall) begin
			unique case (st_r)
				S_IDLE: begin
				end
				S_ADDR: begin
					if (bits_r == 4'h8) begin
						if (shift_r[7:1] == devAddr) begin
							st_nxt = S_ACKA;
							sdaLow_nxt = 1'b1;
							rw_nxt = shift_r[0];
						end else begin
							st_nxt = S_IDLE;
						end
					end
				end
				S_ACKA: begin
					bits_nxt = 4'h0;
					if (rw_r) begin
						loadRd = 1'b1;
					end else begin
						st_nxt = S_INDEX;
						sdaLow_nxt = 1'b0;
					end
				end
				S_INDEX: begin
					if (bits_r == 4'h8) begin
						idx_nxt = shift_r;
						st_nxt = S_ACKI;
						sdaLow_nxt = 1'b1;
					end
				end
				S_ACKI: begin
					st_nxt = S_WRITE;
					sdaLow_nxt = 1'b0;
					bits_nxt = 4'h0;
				end
				S_WRITE: begin
					if (bits_r == 4'h8) begin
						wrEn = 1'b1;
						st_nxt = S_ACKW;
						sdaLow_nxt = 1'b1;
					end
				end
				S_ACKW: begin
					st_nxt = S_WRITE;
					sdaLow_nxt = 1'b0;
					bits_nxt = 4'h0;
					idx_nxt = idx_r + 8'h01;
				end
				S_READ: begin
					if (bits_r == 4'h8) begin
						st_nxt = S_RDACK;
						sdaLow_nxt = 1'b0;
					end else begin
						shift_nxt = {shift_r[6:0], 1'b0};
						sdaLow_nxt = ~shift_r[6];
						bits_nxt = bits_r + 4'h1;
					end
				end
				// acknowledged: next register follows
				S_RDACK: begin
					idx_nxt = idx_r + 8'h01;
					loadRd = 1'b1;
				end
			endcase
		end
		if (loadRd) begin
			shift_nxt = regRead(idx_nxt);
			sdaLow_nxt = ~shift_nxt[7];
			bits_nxt = 4'h1;
			st_nxt = S_READ;
		end
	end

	assign rdClr = loadRd && (idx_nxt == SMDCR_IDX_STATUS);

	// register writes and sticky status
	always_comb begin
		sdnCnt_nxt = sdnCnt_r;
		clkCtl_nxt = clkCtl_r;
		devCtl_nxt = devCtl_r;
		gp_nxt = gp_r;
		cntTgl_nxt = cntTgl_r;
		if (wrEn) begin
			unique case (idx_r)
				SMDCR_IDX_SDN_CNT: begin
					sdnCnt_nxt = shift_r;
					cntTgl_nxt = ~cntTgl_r;
				end
				SMDCR_IDX_CLK: clkCtl_nxt = shift_r;
				SMDCR_IDX_CTRL: devCtl_nxt = shift_r;
				SMDCR_IDX_GP: gp_nxt = shift_r & SMDCR_GP_WMASK;
				default: begin
				end
			endcase
		end
		// battery event sets, set beats read clear
		statBat_nxt = (batEvt & devCtl_r[SMDCR_CTL_BAT_IRQ]) | (statBat_r & ~rdClr);
		// shutdown event sets, set beats read clear
		statSdn_nxt = (sdnEvt & devCtl_r[SMDCR_CTL_SDN_IRQ]) | (statSdn_r & ~rdClr);
		irqDrv_nxt = statBat_r | statSdn_r;
		strapCnt_nxt = strapCnt_r;
		strapHigh_nxt = strapHigh_r;
		if (strapCnt_r != SMDCR_STRAP_CYC) begin
			strapCnt_nxt = strapCnt_r + 2'h1;
			strapHigh_nxt = irqS2_r;
		end
	end

	always_ff @(posedge linkClk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= S_IDLE;
			shift_r <= 8'h00;
			bits_r <= 4'h0;
			sdaLow_r <= 1'b0;
			rw_r <= 1'b0;
			idx_r <= 8'h00;
			sdnCnt_r <= SMDCR_SDN_CNT_RST;
			clkCtl_r <= SMDCR_CLK_RST;
			devCtl_r <= SMDCR_CTRL_RST;
			gp_r <= SMDCR_GP_RST;
			statBat_r <= 1'b0;
			statSdn_r <= 1'b0;
			cntTgl_r <= 1'b0;
			strapCnt_r <= 2'h0;
			strapHigh_r <= 1'b0;
			irqDrv_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			shift_r <= shift_nxt;
			bits_r <= bits_nxt;
			sdaLow_r <= sdaLow_nxt;
			rw_r <= rw_nxt;
			idx_r <= idx_nxt;
			sdnCnt_r <= sdnCnt_nxt;
			clkCtl_r <= clkCtl_nxt;
			devCtl_r <= devCtl_nxt;
			gp_r <= gp_nxt;
			statBat_r <= statBat_nxt;
			statSdn_r <= statSdn_nxt;
			cntTgl_r <= cntTgl_nxt;
			strapCnt_r <= strapCnt_nxt;
			strapHigh_r <= strapHigh_nxt;
			irqDrv_r <= irqDrv_nxt;
		end
	end

	// open-drain pins: value always low, enable active low
	assign sdaOut = 1'b0;
	assign sdaOe_b = ~sdaLow_r;
	assign irqOut = 1'b0;
	assign irqOe_b = ~irqDrv_r;
	assign sdnPullUpEn = ~gp_r[SMDCR_GP_PU];
	assign sdnPullDnEn = gp_r[SMDCR_GP_PD];

	// ***************************************************
	// ref domain: synchronisers
	// ***************************************************
	logic [7:0] ctlS1_r, ctlS2_r; // device control bits, each an independent level
	logic selS1_r, selS2_r; // clock source select
	logic extS1_r, extS2_r, extS3_r; // external 32 kHz clock
	logic bsiS1_r, bsiS2_r; // battery comparator
	logic sdnInS1_r, sdnInS2_r; // shutdown pin
	logic dirS1_r, dirS2_r; // direction pin
	logic tglS1_r, tglS2_r, tglS3_r; // count update toggle

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			{ctlS1_r, ctlS2_r} <= {SMDCR_CTRL_RST, SMDCR_CTRL_RST};
			{selS1_r, selS2_r} <= 2'h0;
			{extS1_r, extS2_r, extS3_r} <= 3'h0;
			{bsiS1_r, bsiS2_r} <= 2'h0;
			{sdnInS1_r, sdnInS2_r} <= 2'h3;
			{dirS1_r, dirS2_r} <= 2'h0;
			{tglS1_r, tglS2_r, tglS3_r} <= 3'h0;
		end else begin
			{ctlS1_r, ctlS2_r} <= {devCtl_r, ctlS1_r};
			{selS1_r, selS2_r} <= {clkCtl_r[SMDCR_CLK_SEL], selS1_r};
			{extS1_r, extS2_r, extS3_r} <= {extClkIn, extS1_r, extS2_r};
			{bsiS1_r, bsiS2_r} <= {bsiIn, bsiS1_r};
			{sdnInS1_r, sdnInS2_r} <= {sdnIn, sdnInS1_r};
			{dirS1_r, dirS2_r} <= {dirPinIn, dirS1_r};
			{tglS1_r, tglS2_r, tglS3_r} <= {cntTgl_r, tglS1_r, tglS2_r};
		end
	end

	// ***************************************************
	// ref domain: timing tick, detection and outputs
	// ***************************************************
	logic [9:0] div_r, div_nxt; // internal oscillator divider
	logic tick; // one 32 kHz period elapsed
	logic [7:0] cntRef_r, cntRef_nxt; // count copy, stable in this domain
	logic reload_r, reload_nxt; // restart pulse in the same cycle the copy lands
	logic bsiDeb, sdnDeb, sdnTrue; // debounced levels and the raw shutdown match
	logic bsiDebD_r, sdnDebD_r; // previous debounced levels
	logic batTgl_nxt, sdnTgl_nxt;
	logic sim1Dn_r, sim1Dn_nxt, sim2Dn_r, sim2Dn_nxt; // power-down requests
	logic autoDir_r, autoDir_nxt, c2b_r, c2b_nxt, bsiLvl_r, bsiLvl_nxt;

	assign tick = selS2_r ? (extS2_r & ~extS3_r) : (div_r == 10'h000);
	assign sdnTrue = (sdnInS2_r == ctlS2_r[SMDCR_CTL_SDN_LVL]);

	always_comb begin
		div_nxt = (div_r == 10'h000) ? SMDCR_OSC_DIV - 10'h001 : div_r - 10'h001;
		cntRef_nxt = cntRef_r;
		// the link copy is held still long before the toggle arrives
		if (tglS2_r ^ tglS3_r) begin
			cntRef_nxt = sdnCnt_r;
		end
		reload_nxt = tglS2_r ^ tglS3_r;
		batTgl_nxt = batTgl_r ^ (bsiDeb & ~bsiDebD_r);
		sdnTgl_nxt = sdnTgl_r ^ (sdnDeb & ~sdnDebD_r);
		sim1Dn_nxt = bsiDeb & ~ctlS2_r[SMDCR_CTL_BSI_NOPD];
		sim2Dn_nxt = sim1Dn_nxt | (sdnDeb & ~ctlS2_r[SMDCR_CTL_SDN_NOPD]);
		autoDir_nxt = ~ctlS2_r[SMDCR_CTL_OE_EN];
		c2b_nxt = ctlS2_r[SMDCR_CTL_OE_EN] & (dirS2_r ^ ctlS2_r[SMDCR_CTL_OE_POL]);
		bsiLvl_nxt = ctlS2_r[SMDCR_CTL_BSI_LVL];
	end

	// both cards held powered down at reset
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 10'h000;
			cntRef_r <= SMDCR_SDN_CNT_RST;
			reload_r <= 1'b0;
			bsiDebD_r <= 1'b0;
			sdnDebD_r <= 1'b0;
			batTgl_r <= 1'b0;
			sdnTgl_r <= 1'b0;
			sim1Dn_r <= 1'b1;
			sim2Dn_r <= 1'b1;
			autoDir_r <= 1'b1;
			c2b_r <= 1'b0;
			bsiLvl_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			cntRef_r <= cntRef_nxt;
			reload_r <= reload_nxt;
			bsiDebD_r <= bsiDeb;
			sdnDebD_r <= sdnDeb;
			batTgl_r <= batTgl_nxt;
			sdnTgl_r <= sdnTgl_nxt;
			sim1Dn_r <= sim1Dn_nxt;
			sim2Dn_r <= sim2Dn_nxt;
			autoDir_r <= autoDir_nxt;
			c2b_r <= c2b_nxt;
			bsiLvl_r <= bsiLvl_nxt;
		end
	end

	// battery counter keeps its reset count; its register lies elsewhere
	smdcr_debounce #(.W(8)) uBsiDeb (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tick(tick),
		.active(bsiS2_r),
		.count(SMDCR_BSI_CNT_RST),
		.reload(1'b0),
		.deb(bsiDeb)
	);

	smdcr_debounce #(.W(8)) uSdnDeb (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tick(tick),
		.active(sdnTrue),
		.count(cntRef_r),
		.reload(reload_r),
		.deb(sdnDeb)
	);

	assign sim1PowerDown = sim1Dn_r;
	assign sim2PowerDown = sim2Dn_r;
	assign autoDirEn = autoDir_r;
	assign dirCardToBb = c2b_r;
	assign bsiLevelSel = bsiLvl_r;

	// ***************************************************
	// checks
	// ***************************************************
	property p_batSet;
		@(posedge linkClk) disable iff (!rst_b)
		(batEvt && devCtl_r[SMDCR_CTL_BAT_IRQ]) |=> statBat_r ##1 !irqOe_b;
	endproperty
	a_batSet: assert property (p_batSet) else $error("battery status not raised");

	property p_batMasked;
		@(posedge linkClk) disable iff (!rst_b)
		(!statBat_r && !devCtl_r[SMDCR_CTL_BAT_IRQ]) |=> !statBat_r;
	endproperty
	a_batMasked: assert property (p_batMasked) else $error("masked battery status set");

	property p_sdnSet;
		@(posedge linkClk) disable iff (!rst_b)
		(sdnEvt && devCtl_r[SMDCR_CTL_SDN_IRQ]) |=> statSdn_r;
	endproperty
	a_sdnSet: assert property (p_sdnSet) else $error("shutdown status not raised");

	property p_rdClr;
		@(posedge linkClk) disable iff (!rst_b)
		(rdClr && !batEvt) |=> !statBat_r;
	endproperty
	a_rdClr: assert property (p_rdClr) else $error("status read did not clear");

	property p_gpWrite;
		@(posedge linkClk) disable iff (!rst_b)
		(wrEn && idx_r == SMDCR_IDX_GP) |=> (gp_r == ($past(shift_r) & SMDCR_GP_WMASK));
	endproperty
	a_gpWrite: assert property (p_gpWrite) else $error("pull register write wrong");

	property p_strap;
		@(posedge linkClk) disable iff (!rst_b)
		(strapCnt_r == SMDCR_STRAP_CYC) |=> $stable(strapHigh_r);
	endproperty
	a_strap: assert property (p_strap) else $error("address strap moved");

	property p_sim1;
		@(posedge ref_clk) disable iff (!rst_b)
		(bsiDeb && !ctlS2_r[SMDCR_CTL_BSI_NOPD]) |=> (sim1Dn_r && sim2Dn_r);
	endproperty
	a_sim1: assert property (p_sim1) else $error("battery power-down missing");

	property p_sim2Only;
		@(posedge ref_clk) disable iff (!rst_b)
		(sdnDeb && !bsiDeb && !ctlS2_r[SMDCR_CTL_SDN_NOPD]) |=> (sim2Dn_r && !sim1Dn_r);
	endproperty
	a_sim2Only: assert property (p_sim2Only) else $error("shutdown power-down wrong");

	property p_dir;
		@(posedge ref_clk) disable iff (!rst_b)
		ctlS2_r[SMDCR_CTL_OE_EN] |=> (c2b_r == ($past(dirS2_r) ^ $past(ctlS2_r[SMDCR_CTL_OE_POL])));
	endproperty
	a_dir: assert property (p_dir) else $error("direction mapping wrong");

	property p_intTick;
		@(posedge ref_clk) disable iff (!rst_b)
		(!selS2_r && !selS1_r && div_r == 10'h001) |=> tick;
	endproperty
	a_intTick: assert property (p_intTick) else $error("internal tick missing");
endmodule // smdcr_top

/* File: tb/smdcr_i2c_master.sv */
// serial bus master model standing in for the baseband processor
`timescale 1ns/10ps
module smdcr_i2c_master import smdcr_pkg::*; (
	output logic scl,
	output logic sdaDrv,
	input wire logic sdaLine
);
	// half bit time, well over four link clocks per phase
	localparam int Q = 300;
	initial begin
		scl = 1'h1;
		sdaDrv = 1'h1;
	end
	// start or repeated start, leaves the clock low
	task automatic start;
		#(Q/2) sdaDrv = 1'h1;
		#(Q/2) scl = 1'h1;
		#Q sdaDrv = 1'h0;
		#Q scl = 1'h0;
	endtask
	// data moves only mid low phase so it never looks like start or stop
	task automatic xfer(input logic [8:0] b, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			#(Q/2) sdaDrv = b[i];
			#(Q/2) scl = 1'h1;
			#(Q/2) r[i] = sdaLine;
			#(Q/2) scl = 1'h0;
		end
	endtask
	task automatic stop;
		#(Q/2) sdaDrv = 1'h0;
		#(Q/2) scl = 1'h1;
		#Q sdaDrv = 1'h1;
		#Q;
	endtask
	// index then data, strap high address
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic ok);
		logic [8:0] r;
		start();
		xfer({SMDCR_ADDR_HIGH, 1'h0, 1'h1}, r);
		ok = !r[0];
		xfer({idx, 1'h1}, r);
		ok &= !r[0];
		xfer({d, 1'h1}, r);
		ok &= !r[0];
		stop();
	endtask
	// set index, repeated start, one byte then nack
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		logic [8:0] r;
		start();
		xfer({SMDCR_ADDR_HIGH, 1'h0, 1'h1}, r);
		xfer({idx, 1'h1}, r);
		start();
		xfer({SMDCR_ADDR_HIGH, 1'h1, 1'h1}, r);
		xfer({8'hff, 1'h1}, r);
		d = r[8:1];
		stop();
	endtask
endmodule // smdcr_i2c_master

/* File: tb/smdcr_top_tb.sv */
// self-checking bench for the detection control register block
`timescale 1ns/10ps
module smdcr_top_tb import smdcr_pkg::*;;
	logic ref_clk = 1'h0;
	logic linkClk = 1'h0;
	logic rst_b = 1'h0;
	logic sdnIn = 1'h1;
	logic bsiIn = 1'h0;
	logic dirPinIn = 1'h0;
	logic extClk = 1'h0; // stand-in external clock, far faster than 32 kHz to keep the run short
	logic scl, sdaDrv, sdaOe_b, irqOe_b, autoDirEn, dirCardToBb;
	logic sdnPullUpEn, sdnPullDnEn, sim1PowerDown, sim2PowerDown;
	int numErrors = 0;
	int totalChecks = 0;
	int cyc = 0;
	// open drain lines with pull-ups; irq line high in reset picks the high address
	wire sdaLine = sdaDrv & sdaOe_b;
	wire irqLine = irqOe_b;
	initial forever #25 ref_clk = ~ref_clk;
	initial begin
		#7;
		forever #24 linkClk = ~linkClk;
	end
	// external clock: period of 40 reference cycles, changed on the falling edge
	always begin
		repeat (20) @(negedge ref_clk);
		extClk = ~extClk;
	end
	smdcr_i2c_master u_mst (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
	smdcr_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .linkClk(linkClk), .sclIn(scl),
		.sdaIn(sdaLine), .sdaOut(), .sdaOe_b(sdaOe_b), .irqIn(irqLine), .irqOut(),
		.irqOe_b(irqOe_b), .extClkIn(extClk), .bsiIn(bsiIn), .sdnIn(sdnIn),
		.dirPinIn(dirPinIn), .bsiLevelSel(), .autoDirEn(autoDirEn),
		.dirCardToBb(dirCardToBb), .sdnPullUpEn(sdnPullUpEn), .sdnPullDnEn(sdnPullDnEn),
		.sim1PowerDown(sim1PowerDown), .sim2PowerDown(sim2PowerDown));
	task automatic closeOut;
		if (numErrors == 0 && totalChecks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bt(input logic seen, input logic exp);
		chk({7'h0, seen}, {7'h0, exp});
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic ok;
		u_mst.wr(idx, d, ok);
		bt(ok, 1'h1);
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		u_mst.rd(idx, d);
		chk(d, exp);
		repeat (6) @(negedge ref_clk);
	endtask
	// hang guard, about 1.6 times the expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			numErrors++;
			closeOut();
		end
	end
	initial begin
		repeat (6) @(negedge ref_clk);
		rst_b = 1'h1;
		repeat (10) @(negedge ref_clk);
		bt(autoDirEn, 1'h1);
		bt(sdnPullUpEn, 1'h1);
		rc(SMDCR_IDX_SDN_CNT, 8'h04);
		rc(SMDCR_IDX_CLK, 8'h00);
		rc(SMDCR_IDX_CTRL, 8'h00);
		wr(SMDCR_IDX_GP, 8'hff);
		rc(SMDCR_IDX_GP, 8'h03);
		bt(sdnPullUpEn, 1'h0);
		bt(sdnPullDnEn, 1'h1);
		// software side: reserved bits written as zero
		wr(SMDCR_IDX_GP, 8'h00);
		bt(sdnPullUpEn, 1'h1);
		wr(SMDCR_IDX_CLK, 8'h80);
		rc(SMDCR_IDX_CLK, 8'h80);
		wr(SMDCR_IDX_CLK, 8'h00);
		wr(SMDCR_IDX_CTRL, 8'h03);
		bt(autoDirEn, 1'h0);
		bt(dirCardToBb, 1'h1);
		wr(SMDCR_IDX_CTRL, 8'h01);
		bt(dirCardToBb, 1'h0);
		dirPinIn = 1'h1;
		repeat (6) @(negedge ref_clk);
		bt(dirCardToBb, 1'h1);
		// zero count bypasses debounce, active low input
		wr(SMDCR_IDX_SDN_CNT, 8'h00);
		wr(SMDCR_IDX_CTRL, 8'h20);
		sdnIn = 1'h0;
		repeat (20) @(negedge ref_clk);
		bt(sim2PowerDown, 1'h1);
		bt(sim1PowerDown, 1'h0);
		bt(irqOe_b, 1'h0);
		rc(SMDCR_IDX_STATUS, 8'h02);
		bt(irqOe_b, 1'h1);
		sdnIn = 1'h1;
		// fast external tick alone can expire a count of four this soon
		wr(SMDCR_IDX_SDN_CNT, 8'h04);
		wr(SMDCR_IDX_CLK, 8'h80);
		sdnIn = 1'h0;
		repeat (100) @(negedge ref_clk);
		bt(sim2PowerDown, 1'h0);
		repeat (200) @(negedge ref_clk);
		bt(sim2PowerDown, 1'h1);
		sdnIn = 1'h1;
		rc(SMDCR_IDX_STATUS, 8'h02);
		wr(SMDCR_IDX_CLK, 8'h00);
		wr(SMDCR_IDX_CTRL, 8'h04);
		bsiIn = 1'h1;
		// under three internal ticks the count of four cannot expire
		repeat (1800) @(negedge ref_clk);
		bt(sim1PowerDown, 1'h0);
		repeat (1700) @(negedge ref_clk);
		bt(sim1PowerDown, 1'h1);
		bt(sim2PowerDown, 1'h1);
		rc(SMDCR_IDX_STATUS, 8'h08);
		closeOut();
	end
endmodule // smdcr_top_tb
